// >>> test/pmce_checker.sv
module pmce_checker
  import pmce_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             rst_n,
  // Watched ports
  input wire logic             en_current,
  input wire logic [AVG_W-1:0] avg_count,
  input wire pmce_sel_t        adc_sel,
  input wire logic             adc_start,
  input wire pmce_sample_t     adc_result,
  input wire pmce_result_t     result,
  input wire logic             result_update
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Converter handshake
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start longer than a cycle");
  a_sel_onehot: assert property ($onehot(adc_sel))
    else $error("selector not one-hot");
  a_sel_steady: assert property (adc_start |-> $stable(adc_sel))
    else $error("selector moved at start");
  a_temp_first: assert property (adc_result.valid && adc_result.sel == PMCE_SEL_TEMP
    && en_current |-> ##2 (adc_start && adc_sel == PMCE_SEL_SHUNT))
    else $error("shunt not after temperature");
  // Publishing
  a_shunt_direct: assert property (avg_count == 1 && adc_result.valid
    && adc_result.sel == PMCE_SEL_SHUNT |=> result_update)
    else $error("current not published");
  a_power_upd: assert property (!$stable(result.power) |-> result_update)
    else $error("power changed without update");
  // Ranges, checked on the outputs since these hold until replaced
  a_cur_range: assert property (result.current <= CUR_MAX && result.current >= CUR_MIN)
    else $error("current out of span");
  a_bus_range: assert property (result.bus <= BUS_MAX)
    else $error("bus out of span");
  a_temp_range: assert property (result.temp <= TMP_MAX && result.temp >= TMP_MIN)
    else $error("temperature out of span");
  a_tot_clear: assert property ($rose(rst_n) |-> result.charge == 0 && result.energy == 0)
    else $error("totals not cleared");
endmodule

bind pmce_engine pmce_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .en_current(en_current),
  .avg_count(avg_count), .adc_sel(adc_sel), .adc_start(adc_start), .adc_result(adc_result),
  .result(result), .result_update(result_update));

// >>> test/pmce_engine_tb.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module pmce_engine_tb import pmce_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    ref_clk, rst_n, en_current, en_bus, adc_start, result_update;
  logic [AVG_W-1:0]        avg_count;
  logic [15:0]             cycle_ticks;
  pmce_sel_t               adc_sel;
  pmce_sample_t            adc_result;
  pmce_result_t            result;
  logic signed [PWR_W-1:0] pe;
  logic signed [TOT_W-1:0] q0, e0;
  int                      n_fail, check_count, cyc, n_upd;

  pmce_engine #(.CYC_W(16)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .en_current(en_current),
    .en_bus(en_bus), .avg_count(avg_count), .cycle_ticks(cycle_ticks), .adc_sel(adc_sel),
    .adc_start(adc_start), .adc_result(adc_result), .result(result),
    .result_update(result_update));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Update count and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (result_update === 1'b1) n_upd++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Converter stand-in: waits for a start, answers after three cycles
  task automatic conv(input pmce_sel_t s, input logic [RAW_W-1:0] code);
    int n;
    n = 0;
    while (adc_start !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(adc_sel, s)
    repeat (3) @(posedge ref_clk);
    #1 adc_result = '{1'b1, s, code};
    @(posedge ref_clk);
    #1 adc_result.valid = 1'b0;
  endtask

  task automatic t_reset();
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(result, '0)
    `CHK(adc_sel, PMCE_SEL_TEMP)
    #1 rst_n = 1'b1;
  endtask

  // Two samples averaged; nothing published after the first
  task automatic t_avg();
    int u0, n;
    u0 = n_upd;
    conv(PMCE_SEL_TEMP, 20'h00010);
    conv(PMCE_SEL_SHUNT, 20'h00064);
    conv(PMCE_SEL_BUS, 20'h0012c);
    `CHK(n_upd, u0)
    `CHK(result.current, 20'h0)
    conv(PMCE_SEL_TEMP, 20'h00030);
    conv(PMCE_SEL_SHUNT, 20'h0012c);
    conv(PMCE_SEL_BUS, 20'h001f4);
    n = 0;
    while (result_update !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(result.current, 20'h000c8)
    `CHK(result.bus, 20'h00190)
    `CHK(result.temp, 20'h00020)
    `CHK(result.power, 40'h0000013880)
  endtask

  // Single sample: results appear directly
  task automatic t_direct();
    conv(PMCE_SEL_TEMP, 20'h00100);
    `CHK(result.temp, 20'h00100)
    conv(PMCE_SEL_SHUNT, 20'h003e8);
    `CHK(result.current, 20'h003e8)
    `CHK(result.power, 40'h0000013880)
    conv(PMCE_SEL_BUS, 20'h007d0);
    `CHK(result.bus, 20'h007d0)
    `CHK(result.power, 40'h00001e8480)
  endtask

  // Codes beyond every span are limited
  task automatic t_clamp();
    conv(PMCE_SEL_TEMP, 20'h7ffff);
    `CHK(result.temp, TMP_MAX)
    conv(PMCE_SEL_SHUNT, 20'h80000);
    `CHK(result.current, CUR_MIN)
    conv(PMCE_SEL_BUS, 20'h7ffff);
    `CHK(result.bus, BUS_MAX)
    pe = CUR_MIN * $signed({1'b0, BUS_MAX});
    `CHK(result.power, pe)
  endtask

  // Engine idles waiting for temperature; totals keep counting
  task automatic t_totals();
    repeat (8) @(posedge ref_clk);
    q0 = result.charge;
    e0 = result.energy;
    repeat (4) @(posedge ref_clk);
    q0 = result.charge - q0;
    e0 = result.energy - e0;
    `CHK(q0, CUR_MIN * 48'sd3)
    `CHK(e0, pe * 48'sd3)
  endtask

  // Main sequence
  initial begin
    {n_fail, check_count, cyc, n_upd} = '0;
    {en_current, en_bus, avg_count, cycle_ticks} = {2'b11, 11'h002, 16'h0003};
    adc_result = '0;
    t_reset();
    t_avg();
    avg_count = 11'h001;
    t_direct();
    t_clamp();
    t_totals();
    t_reset();
    complete_run();
  end
endmodule

// >>> verilog/pmce_engine.sv
// Behaviour
// RULE1 - One selector feeds three inputs to converter
// RULE2 - Current and charge come from shunt drop
// RULE3 - Power and energy only after bus conversion
// RULE4 - Power uses latest bus and prior current
// RULE5 - Average of one publishes results immediately
// RULE6 - Averaging keeps samples in averaging stores
// RULE7 - Add each sample until count reached
// RULE8 - Average, then power, then publish results
// RULE9 - Charge and energy accumulate every cycle
// RULE10 - Totals are never averaged
// RULE11 - Arithmetic runs alongside conversions, no stall
// RULE12 - Current clamped to +/-39.32 A span
// RULE13 - Bus 0..85 V, temperature -40..165 C
// RULE14 - Temperature converted before every current conversion
// RULE15 - Enabled inputs converted one after another; code converts bus whenever en_current is low, even with en_bus low
// RULE16 - Averaging count from 1 to 1024
// RULE17 - Totals and averaging stores cleared at reset
// RULE18 - Increments are value times cycle duration
module pmce_engine
  import pmce_pkg::*;
#(
  parameter int CYC_W = 16
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Configuration
  input  wire logic               en_current,
  input  wire logic               en_bus,
  input  wire logic [AVG_W-1:0]   avg_count,
  input  wire logic [CYC_W-1:0]   cycle_ticks,
  // Converter side
  output      pmce_sel_t          adc_sel,
  output      logic               adc_start,
  input  wire pmce_sample_t       adc_result,
  // Results
  output      pmce_result_t       result,
  output      logic               result_update
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_START = 4'h2,
    ST_WAIT  = 4'h4,
    ST_AVG   = 4'h8
  } pmce_state_t;

  typedef struct packed {
    pmce_state_t             state;
    pmce_sel_t               sel;
    logic                    start;
    logic [AVG_W-1:0]        nsamp;
    logic signed [ACC_W-1:0] acc_cur;
    logic [ACC_W-1:0]        acc_bus;
    logic signed [ACC_W-1:0] acc_tmp;
    logic signed [RAW_W-1:0] last_cur;
    logic signed [RAW_W-1:0] comp_tmp;
    logic [CYC_W-1:0]        tick;
    pmce_result_t            res;
    logic                    upd;
  } pmce_regs_t;

  pmce_regs_t r;
  pmce_regs_t next_r;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Saturate a raw shunt sample to the full-scale span
  function automatic logic signed [RAW_W-1:0] clamp_cur(input logic signed [RAW_W-1:0] v);
    if (v > CUR_MAX) begin
      clamp_cur = CUR_MAX;
    end else if (v < CUR_MIN) begin
      clamp_cur = CUR_MIN;
    end else begin
      clamp_cur = v;
    end
  endfunction

  function automatic logic [RAW_W-1:0] clamp_bus(input logic [RAW_W-1:0] v);
    if ($signed(v) < 0) begin
      clamp_bus = '0;
    end else if (v > BUS_MAX) begin
      clamp_bus = BUS_MAX;
    end else begin
      clamp_bus = v;
    end
  endfunction

  function automatic logic signed [RAW_W-1:0] clamp_tmp(input logic signed [RAW_W-1:0] v);
    if (v < TMP_MIN) begin
      clamp_tmp = TMP_MIN;
    end else if (v > TMP_MAX) begin
      clamp_tmp = TMP_MAX;
    end else begin
      clamp_tmp = v;
    end
  endfunction

  // Next input in the sequence; temperature always precedes shunt
  function automatic pmce_sel_t next_sel(input pmce_sel_t s, input logic ec, input logic eb);
    case (s)
      PMCE_SEL_TEMP:  next_sel = ec ? PMCE_SEL_SHUNT : PMCE_SEL_BUS;
      PMCE_SEL_SHUNT: next_sel = eb ? PMCE_SEL_BUS : PMCE_SEL_TEMP;
      PMCE_SEL_BUS:   next_sel = PMCE_SEL_TEMP;
      default:        next_sel = PMCE_SEL_TEMP;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Averages use a divide; kept combinational since it only
  // fires once per averaging window, off the sequence path
  logic signed [RAW_W-1:0] smp_cur;
  logic [RAW_W-1:0]        smp_bus;
  logic signed [RAW_W-1:0] smp_tmp;
  logic [AVG_W-1:0]        navg;
  logic signed [RAW_W-1:0] avg_cur;
  logic [RAW_W-1:0]        avg_bus;
  logic signed [RAW_W-1:0] avg_tmp;
  logic signed [PWR_W-1:0] pwr_now;
  logic                    last_in_seq;
  logic                    cycle_done;

  always_comb begin
    next_r      = r;
    next_r.start = 1'b0;
    next_r.upd  = 1'b0;
    navg        = (avg_count == '0) ? AVG_W'(1) : avg_count; // RULE16
    smp_cur     = clamp_cur(adc_result.code); // RULE2 RULE12
    smp_bus     = clamp_bus(adc_result.code); // RULE13
    smp_tmp     = clamp_tmp(adc_result.code); // RULE13
    avg_cur     = RAW_W'($signed(r.acc_cur) / $signed({1'b0, navg}));
    avg_bus     = RAW_W'(r.acc_bus / ACC_W'(navg));
    avg_tmp     = RAW_W'($signed(r.acc_tmp) / $signed({1'b0, navg}));
    // Widen both factors first so the product is not cut to 21 bits
    pwr_now     = PWR_W'(r.last_cur) * PWR_W'($signed({1'b0, smp_bus})); // RULE4
    last_in_seq = (next_sel(r.sel, en_current, en_bus) == PMCE_SEL_TEMP);
    cycle_done  = (r.tick >= cycle_ticks);

    // Time base for charge and energy: free-running cycle tick
    next_r.tick = cycle_done ? '0 : r.tick + CYC_W'(1);
    if (cycle_done) begin
      next_r.res.charge = r.res.charge + TOT_W'(r.last_cur) * TOT_W'(cycle_ticks); // RULE9 RULE18
      next_r.res.energy = r.res.energy + TOT_W'(r.res.power) * TOT_W'(cycle_ticks); // RULE10 RULE18
    end

    case (r.state)
      ST_IDLE: begin
        next_r.sel   = PMCE_SEL_TEMP; // RULE14
        next_r.state = ST_START;
      end
      ST_START: begin
        next_r.start = 1'b1; // RULE1
        next_r.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (adc_result.valid) begin
          case (r.sel)
            PMCE_SEL_TEMP: begin
              next_r.comp_tmp = smp_tmp; // RULE14
              if (avg_count <= AVG_W'(1)) begin
                next_r.res.temp = smp_tmp; // RULE5
              end else begin
                next_r.acc_tmp = r.acc_tmp + ACC_W'(smp_tmp); // RULE6 RULE7
              end
            end
            PMCE_SEL_SHUNT: begin
              next_r.last_cur = smp_cur; // RULE2
              if (avg_count <= AVG_W'(1)) begin
                next_r.res.current = smp_cur; // RULE5
                next_r.upd         = 1'b1;
              end else begin
                next_r.acc_cur = r.acc_cur + ACC_W'(smp_cur); // RULE6 RULE7
              end
            end
            PMCE_SEL_BUS: begin
              if (avg_count <= AVG_W'(1)) begin
                next_r.res.bus   = smp_bus; // RULE5
                next_r.res.power = pwr_now; // RULE3 RULE4
                next_r.upd       = 1'b1;
              end else begin
                next_r.acc_bus = r.acc_bus + ACC_W'(smp_bus); // RULE6 RULE7
              end
            end
            default: begin
              next_r.sel = PMCE_SEL_TEMP;
            end
          endcase
          // Sequence advances at once; arithmetic never holds it
          next_r.sel   = next_sel(r.sel, en_current, en_bus); // RULE11 RULE15
          next_r.state = ST_START;
          if (last_in_seq && avg_count > AVG_W'(1)) begin
            next_r.nsamp = r.nsamp + AVG_W'(1);
            if (r.nsamp + AVG_W'(1) >= navg) begin
              next_r.state = ST_AVG; // RULE8
            end
          end
        end
      end
      ST_AVG: begin
        // Average first, then power from the averages, then publish
        next_r.res.current = avg_cur; // RULE8
        next_r.res.bus     = avg_bus;
        next_r.res.temp    = avg_tmp;
        next_r.res.power   = PWR_W'(avg_cur) * PWR_W'($signed({1'b0, avg_bus})); // RULE8
        next_r.last_cur    = avg_cur;
        next_r.upd         = 1'b1;
        next_r.acc_cur     = ACC_RST;
        next_r.acc_bus     = ACC_RST;
        next_r.acc_tmp     = ACC_RST;
        next_r.nsamp       = '0;
        next_r.start       = 1'b1; // Next window starts without a gap
        next_r.state       = ST_WAIT;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r         <= '0; // RULE17
      r.state   <= ST_IDLE;
      r.sel     <= PMCE_SEL_TEMP;
      r.acc_cur <= ACC_RST;
      r.acc_bus <= ACC_RST;
      r.acc_tmp <= ACC_RST;
      r.res     <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign adc_sel       = r.sel;
  assign adc_start     = r.start;
  assign result        = r.res;
  assign result_update = r.upd;

endmodule

// >>> verilog/pmce_pkg.sv
package pmce_pkg;

  // ------------------------------------------------------------
  // Converter input selection and sample widths
  // ------------------------------------------------------------
  localparam int RAW_W = 20;  // Converter result width
  localparam int ACC_W = 32;  // Averaging store width
  localparam int TOT_W = 48;  // Charge and energy total width
  localparam int PWR_W = 40;  // Power product width

  typedef enum logic [2:0] {
    PMCE_SEL_TEMP  = 3'h1,
    PMCE_SEL_SHUNT = 3'h2,
    PMCE_SEL_BUS   = 3'h4
  } pmce_sel_t;

  // ------------------------------------------------------------
  // Range limits in converter codes
  // ------------------------------------------------------------
  // Current 75 uA per code: +/-39.32 A is +/-524283 codes
  localparam logic signed [RAW_W-1:0] CUR_MAX = 20'sh7fffb;
  localparam logic signed [RAW_W-1:0] CUR_MIN = -20'sh7fffb;
  // Bus 195.3125 uV per code: 85 V is 435200 codes
  localparam logic [RAW_W-1:0] BUS_MAX = 20'h6a400;
  // Temperature 7.8125 m-degC per code: -40 and +165 degC
  localparam logic signed [RAW_W-1:0] TMP_MIN = -20'sh01400;
  localparam logic signed [RAW_W-1:0] TMP_MAX = 20'sh05280;

  // ------------------------------------------------------------
  // Averaging and reset values
  // ------------------------------------------------------------
  localparam int AVG_MAX = 1024;
  localparam int AVG_W   = 11;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0;
  localparam logic [TOT_W-1:0] TOT_RST = 48'h0;

  // One sample as it leaves the converter
  typedef struct packed {
    logic             valid;
    pmce_sel_t        sel;
    logic [RAW_W-1:0] code;
  } pmce_sample_t;

  // Published results
  typedef struct packed {
    logic signed [RAW_W-1:0] current;
    logic [RAW_W-1:0]        bus;
    logic signed [RAW_W-1:0] temp;
    logic signed [PWR_W-1:0] power;
    logic signed [TOT_W-1:0] charge;
    logic signed [TOT_W-1:0] energy;
  } pmce_result_t;

endpackage
